// >>> src/audio_dsp_control_registers.sv
// sound-processing control register bank behind a two-wire serial control port
// assumes scl/sda arrive asynchronously from pins; audio strobes come from logic on clk
`timescale 1ns/100ps
`default_nettype none
module audio_dsp_control_registers #(
    parameter logic [6:0] dev_addr = 7'h2A // arbitrary default, strap per board
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic sample_valid,
    input wire logic sample_sign,
    output logic [3:0] attack_threshold,
    output logic [3:0] attack_speed,
    output logic [3:0] release_threshold,
    output logic [3:0] release_speed,
    output logic signed [5:0] high_shelf_gain_db,
    output logic high_shelf_gain_valid,
    output logic [1:0] high_shelf_corner,
    output logic signed [5:0] low_shelf_gain_db,
    output logic low_shelf_gain_valid,
    output logic [1:0] low_shelf_corner,
    output logic [8:0] dc_block_coeff,
    output logic [7:0] gain_code,
    output logic [1:0] deemph_select,
    output logic hard_mute_active,
    output logic mute_pwm,
    output logic [7:0] soft_mute_gain,
    output logic [7:0] output_power_cap
);
    if (dev_addr < 7'h08 || dev_addr > 7'h77) begin : g_addr_check
        $error("dev_addr falls in a reserved address range");
    end

    // pin synchronisers: three stages, accept a level once stages two and three agree
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_f;
    logic sda_f;
    logic scl_prev;
    logic sda_prev;
    always_ff @(posedge clk) begin
        if (srst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_i};
            sda_sync <= {sda_sync[1:0], sda_i};
            scl_f <= (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
            sda_f <= (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
            scl_prev <= scl_f;
            sda_prev <= sda_f;
        end
    end
    wire scl_rise = scl_f && !scl_prev;
    wire scl_fall = !scl_f && scl_prev;
    wire start_seen = scl_f && scl_prev && sda_prev && !sda_f;
    wire stop_seen = scl_f && scl_prev && !sda_prev && sda_f;

    // field storage
    logic [4:0] high_shelf_code;
    logic [4:0] low_shelf_code;
    logic zero_cross_update_en;
    logic [3:0] gain_spare;
    logic [7:0] gain_code_req;
    logic hard_mute;
    logic soft_mute;

    // serial engine state
    dsp_ctrl_pkg::link_state_type state;
    dsp_ctrl_pkg::link_state_type ack_next;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic byte_sel;
    logic [7:0] ptr;
    logic [7:0] msb_hold;
    logic master_nack;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [15:0] wr_data;

    wire [15:0] rd_word =
        (ptr == dsp_ctrl_pkg::REG_COMP) ? {attack_threshold, attack_speed, release_threshold, release_speed} :
        (ptr == dsp_ctrl_pkg::REG_TONE) ? {2'h0, high_shelf_code, high_shelf_corner, low_shelf_code,
                                           low_shelf_corner} :
        (ptr == dsp_ctrl_pkg::REG_DCBLK) ? {7'h00, dc_block_coeff} :
        (ptr == dsp_ctrl_pkg::REG_GAIN) ? {3'h0, zero_cross_update_en, gain_spare, gain_code_req} :
        (ptr == dsp_ctrl_pkg::REG_MUTE) ? {4'h0, deemph_select, hard_mute, soft_mute, output_power_cap} :
        16'h0000;
    wire [7:0] tx_byte = byte_sel ? rd_word[7:0] : rd_word[15:8];
    wire [2:0] tx_idx = 3'(4'h7 - bit_cnt);
    wire byte_done = (bit_cnt == dsp_ctrl_pkg::BITS_PER_BYTE);
    wire addr_match = (shift[7:1] == dev_addr);
    wire receiving = (state == dsp_ctrl_pkg::st_addr) || (state == dsp_ctrl_pkg::st_ptr) ||
                     (state == dsp_ctrl_pkg::st_wdata);

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= dsp_ctrl_pkg::st_idle;
            ack_next <= dsp_ctrl_pkg::st_idle;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            byte_sel <= 1'b0;
            ptr <= 8'h00;
            msb_hold <= 8'h00;
            master_nack <= 1'b0;
            sda_oe <= 1'b0;
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 16'h0000;
        end else begin
            wr_en <= 1'b0;
            if (start_seen) begin
                state <= dsp_ctrl_pkg::st_addr;
                bit_cnt <= 4'h0;
                byte_sel <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_seen) begin
                state <= dsp_ctrl_pkg::st_idle;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if (receiving) begin
                    shift <= {shift[6:0], sda_f};
                    bit_cnt <= bit_cnt + 4'h1;
                end else if (state == dsp_ctrl_pkg::st_rack) begin
                    master_nack <= sda_f;
                    byte_sel <= !byte_sel;
                    ptr <= byte_sel ? ptr + 8'h01 : ptr;
                end
            end else if (scl_fall) begin
                case (state)
                    dsp_ctrl_pkg::st_addr: begin
                        if (byte_done) begin
                            state <= addr_match ? dsp_ctrl_pkg::st_ack : dsp_ctrl_pkg::st_idle;
                            sda_oe <= addr_match;
                            ack_next <= shift[0] ? dsp_ctrl_pkg::st_rdata : dsp_ctrl_pkg::st_ptr;
                        end
                    end
                    dsp_ctrl_pkg::st_ptr: begin
                        if (byte_done) begin
                            ptr <= shift;
                            byte_sel <= 1'b0;
                            state <= dsp_ctrl_pkg::st_ack;
                            sda_oe <= 1'b1;
                            ack_next <= dsp_ctrl_pkg::st_wdata;
                        end
                    end
                    dsp_ctrl_pkg::st_wdata: begin
                        if (byte_done) begin
                            // high byte held until the low byte lands so a word never updates half-way
                            msb_hold <= shift;
                            wr_en <= byte_sel;
                            wr_addr <= ptr;
                            wr_data <= {msb_hold, shift};
                            ptr <= byte_sel ? ptr + 8'h01 : ptr;
                            byte_sel <= !byte_sel;
                            state <= dsp_ctrl_pkg::st_ack;
                            sda_oe <= 1'b1;
                            ack_next <= dsp_ctrl_pkg::st_wdata;
                        end
                    end
                    dsp_ctrl_pkg::st_ack: begin
                        state <= ack_next;
                        if (ack_next == dsp_ctrl_pkg::st_rdata) begin
                            sda_oe <= !tx_byte[7];
                            bit_cnt <= 4'h1;
                        end else begin
                            sda_oe <= 1'b0;
                            bit_cnt <= 4'h0;
                        end
                    end
                    dsp_ctrl_pkg::st_rdata: begin
                        if (byte_done) begin
                            sda_oe <= 1'b0;
                            state <= dsp_ctrl_pkg::st_rack;
                        end else begin
                            sda_oe <= !tx_byte[tx_idx];
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                    dsp_ctrl_pkg::st_rack: begin
                        state <= master_nack ? dsp_ctrl_pkg::st_idle : dsp_ctrl_pkg::st_rdata;
                        sda_oe <= master_nack ? 1'b0 : !tx_byte[7];
                        bit_cnt <= 4'h1;
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // register writes
    wire wr_comp = wr_en && (wr_addr == dsp_ctrl_pkg::REG_COMP);
    wire wr_tone = wr_en && (wr_addr == dsp_ctrl_pkg::REG_TONE);
    wire wr_dcblk = wr_en && (wr_addr == dsp_ctrl_pkg::REG_DCBLK);
    wire wr_gain = wr_en && (wr_addr == dsp_ctrl_pkg::REG_GAIN);
    wire wr_mute = wr_en && (wr_addr == dsp_ctrl_pkg::REG_MUTE);
    always_ff @(posedge clk) begin
        if (srst) begin
            attack_threshold <= dsp_ctrl_pkg::RST_ATTACK_THR;
            attack_speed <= dsp_ctrl_pkg::RST_ATTACK_SPD;
            release_threshold <= dsp_ctrl_pkg::RST_RELEASE_THR;
            release_speed <= dsp_ctrl_pkg::RST_RELEASE_SPD;
            high_shelf_code <= dsp_ctrl_pkg::RST_SHELF_GAIN;
            high_shelf_corner <= dsp_ctrl_pkg::RST_SHELF_CORNER;
            low_shelf_code <= dsp_ctrl_pkg::RST_SHELF_GAIN;
            low_shelf_corner <= dsp_ctrl_pkg::RST_SHELF_CORNER;
            dc_block_coeff <= dsp_ctrl_pkg::RST_DC_COEFF;
            zero_cross_update_en <= dsp_ctrl_pkg::RST_ZC_EN;
            gain_spare <= dsp_ctrl_pkg::RST_GAIN_SPARE;
            gain_code_req <= dsp_ctrl_pkg::RST_GAIN_CODE;
            deemph_select <= dsp_ctrl_pkg::RST_DEEMPH;
            hard_mute <= dsp_ctrl_pkg::RST_HARD_MUTE;
            soft_mute <= dsp_ctrl_pkg::RST_SOFT_MUTE;
            output_power_cap <= dsp_ctrl_pkg::RST_POWER_CAP;
        end else begin
            if (wr_comp) begin
                attack_threshold <= wr_data[15:12];
                attack_speed <= wr_data[11:8];
                release_threshold <= wr_data[7:4];
                release_speed <= wr_data[3:0];
            end
            if (wr_tone) begin
                high_shelf_code <= wr_data[13:9];
                high_shelf_corner <= wr_data[8:7];
                low_shelf_code <= wr_data[6:2];
                low_shelf_corner <= wr_data[1:0];
            end
            if (wr_dcblk) begin
                dc_block_coeff <= wr_data[8:0];
            end
            if (wr_gain) begin
                zero_cross_update_en <= wr_data[dsp_ctrl_pkg::ZC_BIT];
                gain_spare <= wr_data[11:8];
                gain_code_req <= wr_data[7:0];
            end
            if (wr_mute) begin
                deemph_select <= wr_data[11:10];
                hard_mute <= wr_data[dsp_ctrl_pkg::HARD_MUTE_BIT];
                soft_mute <= wr_data[dsp_ctrl_pkg::SOFT_MUTE_BIT];
                output_power_cap <= wr_data[7:0];
            end
        end
    end

    // applied settings: decoded gain, zero-crossing gain update, hard mute toggle
    logic last_sign;
    wire zero_cross = sample_valid && (sample_sign != last_sign);
    wire gain_apply = !zero_cross_update_en || zero_cross;
    wire hs_ok = (high_shelf_code <= dsp_ctrl_pkg::SHELF_CODE_MAX);
    wire ls_ok = (low_shelf_code <= dsp_ctrl_pkg::SHELF_CODE_MAX);
    always_ff @(posedge clk) begin
        if (srst) begin
            last_sign <= 1'b0;
            gain_code <= dsp_ctrl_pkg::RST_GAIN_CODE;
            high_shelf_gain_db <= 6'sh00;
            high_shelf_gain_valid <= 1'b1;
            low_shelf_gain_db <= 6'sh00;
            low_shelf_gain_valid <= 1'b1;
            hard_mute_active <= 1'b0;
            mute_pwm <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            last_sign <= sample_valid ? sample_sign : last_sign;
            gain_code <= gain_apply ? gain_code_req : gain_code;
            high_shelf_gain_db <= dsp_ctrl_pkg::shelf_db(high_shelf_code);
            high_shelf_gain_valid <= hs_ok;
            low_shelf_gain_db <= dsp_ctrl_pkg::shelf_db(low_shelf_code);
            low_shelf_gain_valid <= ls_ok;
            hard_mute_active <= hard_mute;
            // one-clock toggle keeps duty exactly half whatever the audio rate
            mute_pwm <= hard_mute ? !mute_pwm : 1'b0;
            sda_o <= 1'b0;
        end
    end

    ramp_if rp ();
    assign rp.mute_req = soft_mute;
    assign rp.step = sample_valid;
    soft_mute_ramp u_ramp (
        .clk(clk),
        .srst(srst),
        .rp(rp.ramp)
    );
    assign soft_mute_gain = rp.gain;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    chk_comp_defaults: assert property ($fell(srst) |->
        {attack_threshold, attack_speed, release_threshold, release_speed} ==
        {dsp_ctrl_pkg::RST_ATTACK_THR, dsp_ctrl_pkg::RST_ATTACK_SPD, dsp_ctrl_pkg::RST_RELEASE_THR,
         dsp_ctrl_pkg::RST_RELEASE_SPD})
        else $error("compressor fields lost reset value");
    chk_comp_write: assert property (wr_comp |=>
        {attack_threshold, attack_speed, release_threshold, release_speed} == $past(wr_data))
        else $error("compressor fields not stored");
    chk_shelf_decode: assert property (1'b1 |=>
        high_shelf_gain_db == dsp_ctrl_pkg::shelf_db($past(high_shelf_code)))
        else $error("high shelf gain decode wrong");
    // reserved codes stay readable but must never reach the tone filter as a gain
    chk_reserved_code: assert property (1'b1 |->
        (low_shelf_gain_valid == ($past(low_shelf_code) <= dsp_ctrl_pkg::SHELF_CODE_MAX)) &&
        (low_shelf_gain_valid || low_shelf_gain_db == 6'sh00))
        else $error("reserved shelf code given a gain");
    chk_dc_write: assert property (wr_dcblk |=> dc_block_coeff == $past(wr_data[8:0]))
        else $error("dc block coefficient not stored");
    chk_zc_hold: assert property (zero_cross_update_en && !zero_cross |=> $stable(gain_code))
        else $error("gain changed away from a zero crossing");
    chk_zc_direct: assert property (!zero_cross_update_en |=> gain_code == $past(gain_code_req))
        else $error("gain not applied at once with zero-cross off");
    chk_pwm_half: assert property (hard_mute ##1 hard_mute |=> mute_pwm != $past(mute_pwm, 1))
        else $error("hard mute output not toggling");
    chk_cap_write: assert property (wr_mute |=> output_power_cap == $past(wr_data[7:0]))
        else $error("power cap not stored");
    chk_gain_store: assert property (wr_gain |=>
        {zero_cross_update_en, gain_spare, gain_code_req} == $past(wr_data[12:0]))
        else $error("gain register fields not stored");
    chk_mute_store: assert property (wr_mute |=>
        {deemph_select, hard_mute, soft_mute} == $past(wr_data[11:8]))
        else $error("mute fields not stored");
    chk_pwm_off: assert property (!hard_mute |=> !mute_pwm)
        else $error("pwm running without hard mute");
    chk_start_release: assert property (start_seen |=> !sda_oe)
        else $error("data line held across a start");
    chk_tone_back: assert property (wr_tone |=>
        {high_shelf_code, high_shelf_corner, low_shelf_code, low_shelf_corner} == $past(wr_data[13:0]))
        else $error("tone register fields not stored");
    cov_hard_mute: cover property (hard_mute ##1 mute_pwm);
    cov_reg_write: cover property (wr_en ##[1:400] wr_en);
    cov_reg_read: cover property (state == dsp_ctrl_pkg::st_rack ##1 state == dsp_ctrl_pkg::st_rack);
    cov_zc_update: cover property (zero_cross_update_en && zero_cross && gain_code != gain_code_req);
endmodule : audio_dsp_control_registers
`default_nettype wire

// >>> src/dsp_ctrl_pkg.sv
// constants, field layout and reset values of the sound-processing control registers
// assumes 16-bit registers addressed by an 8-bit pointer over the two-wire control port
// Behaviour
// - attack threshold nibble 15:12, reset 1001
// - attack speed nibble 11:8, reset 0010
// - release threshold nibble 7:4, reset 1011
// - release speed nibble 3:0, reset 1010
// - tone gain code: 2 dB steps from -18
// - tone codes above 10010 reserved, no gain
// - high shelf corner bits 8:7, reset 01
// - low shelf gain bits 6:2, reset 01001
// - low shelf corner bits 1:0, reset 01
// - dc block coefficient 9 bits, reset 0x04
// - zero-cross enable delays gain update to crossing
// - de-emphasis select bits 11:10, reset 00
// - hard mute gives 50 % duty output
// - soft mute ramps down/up raised cosine
// - power cap low byte, reset 0xBD
package dsp_ctrl_pkg;
    localparam logic [7:0] REG_COMP = 8'h10;
    localparam logic [7:0] REG_TONE = 8'h11;
    localparam logic [7:0] REG_DCBLK = 8'h12;
    localparam logic [7:0] REG_GAIN = 8'h13;
    localparam logic [7:0] REG_MUTE = 8'h14;
    localparam logic [3:0] RST_ATTACK_THR = 4'h9;
    localparam logic [3:0] RST_ATTACK_SPD = 4'h2;
    localparam logic [3:0] RST_RELEASE_THR = 4'hB;
    localparam logic [3:0] RST_RELEASE_SPD = 4'hA;
    localparam logic [4:0] RST_SHELF_GAIN = 5'h09;
    localparam logic [1:0] RST_SHELF_CORNER = 2'h1;
    localparam logic [8:0] RST_DC_COEFF = 9'h004;
    localparam logic RST_ZC_EN = 1'b1;
    localparam logic [3:0] RST_GAIN_SPARE = 4'h0;
    localparam logic [7:0] RST_GAIN_CODE = 8'hBD;
    localparam logic [1:0] RST_DEEMPH = 2'h0;
    localparam logic RST_HARD_MUTE = 1'b0;
    localparam logic RST_SOFT_MUTE = 1'b0;
    localparam logic [7:0] RST_POWER_CAP = 8'hBD;
    localparam logic [4:0] SHELF_CODE_MAX = 5'h12;
    localparam logic signed [5:0] SHELF_DB_OFFSET = 6'sh12;
    localparam int ZC_BIT = 12;
    localparam int HARD_MUTE_BIT = 9;
    localparam int SOFT_MUTE_BIT = 8;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] RAMP_LAST = 4'hF;
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_addr = 3'b001,
        st_ptr = 3'b010,
        st_wdata = 3'b011,
        st_ack = 3'b100,
        st_rdata = 3'b101,
        st_rack = 3'b110
    } link_state_type;
    function automatic logic signed [5:0] shelf_db(input logic [4:0] code);
        if (code > SHELF_CODE_MAX) begin
            return 6'sh00;
        end
        return $signed({code, 1'b0}) - SHELF_DB_OFFSET;
    endfunction : shelf_db
endpackage : dsp_ctrl_pkg

// >>> src/ramp_if.sv
// carrier between the register bank and the soft-mute ramp
// assumes both ends share one clock
`timescale 1ns/100ps
`default_nettype none
interface ramp_if;
    logic mute_req;
    logic step;
    logic [7:0] gain;
    logic settled;
    modport ctrl (output mute_req, output step, input gain, input settled);
    modport ramp (input mute_req, input step, output gain, output settled);
endinterface : ramp_if
`default_nettype wire

// >>> src/soft_mute_ramp.sv
// raised-cosine soft-mute gain ramp, one table step per audio sample
// assumes step is a one-cycle strobe from the same clock
`timescale 1ns/100ps
`default_nettype none
module soft_mute_ramp (
    input wire logic clk,
    input wire logic srst,
    ramp_if.ramp rp
);
    logic [3:0] phase;
    // table of 255*(1+cos(pi*i/15))/2, kept as constants to avoid a multiplier
    function automatic logic [7:0] cosine_gain(input logic [3:0] i);
        case (i)
            4'h0: return 8'hFF;
            4'h1: return 8'hFC;
            4'h2: return 8'hF3;
            4'h3: return 8'hE4;
            4'h4: return 8'hD1;
            4'h5: return 8'hBB;
            4'h6: return 8'hA4;
            4'h7: return 8'h8C;
            4'h8: return 8'h73;
            4'h9: return 8'h5B;
            4'hA: return 8'h44;
            4'hB: return 8'h2E;
            4'hC: return 8'h1B;
            4'hD: return 8'h0C;
            4'hE: return 8'h03;
            default: return 8'h00;
        endcase
    endfunction : cosine_gain
    wire go_down = rp.step && rp.mute_req && (phase != dsp_ctrl_pkg::RAMP_LAST);
    wire go_up = rp.step && !rp.mute_req && (phase != 4'h0);
    wire [3:0] next_phase = go_down ? phase + 4'h1 : (go_up ? phase - 4'h1 : phase);
    always_ff @(posedge clk) begin
        if (srst) begin
            phase <= 4'h0;
            rp.gain <= 8'hFF;
            rp.settled <= 1'b1;
        end else begin
            phase <= next_phase;
            rp.gain <= cosine_gain(next_phase);
            rp.settled <= rp.mute_req ? (next_phase == dsp_ctrl_pkg::RAMP_LAST) : (next_phase == 4'h0);
        end
    end
    chk_ramp_falls: assert property (@(posedge clk) disable iff (srst)
        rp.mute_req && rp.step && phase != dsp_ctrl_pkg::RAMP_LAST |=> rp.gain < $past(rp.gain))
        else $error("soft mute gain did not fall");
    chk_ramp_rises: assert property (@(posedge clk) disable iff (srst)
        !rp.mute_req && rp.step && phase != 4'h0 |=> rp.gain > $past(rp.gain))
        else $error("soft mute gain did not rise");
    cov_ramp_full: cover property (@(posedge clk) disable iff (srst) rp.mute_req && rp.settled);
endmodule : soft_mute_ramp
`default_nettype wire

// >>> test/serial_host.sv
// two-wire host model: 16-bit register writes and reads, high byte first
// assumes the bench resolves the open-drain data line into sda_line
`timescale 1ns/100ps
`default_nettype none
module serial_host #(parameter logic [6:0] dev_addr = 7'h2A) (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl = 1'b1,
    output logic sda_drv = 1'b1,
    output logic [7:0] missed = 8'h00
);
    // ten clocks a phase stays clear of the three-flop pin filter
    task automatic step(input logic c, input logic d);
        repeat (10) @(posedge clk);
        scl <= c;
        sda_drv <= d;
    endtask : step
    task automatic bit_io(input logic d, output logic q);
        step(1'b0, sda_drv);
        step(1'b0, d);
        step(1'b1, d);
        repeat (10) @(posedge clk);
        #1 q = sda_line;
    endtask : bit_io
    // start is (1,0), stop is (0,1); data moves only with scl low before it
    task automatic cond(input logic a, input logic b);
        step(1'b0, sda_drv);
        step(1'b0, a);
        step(1'b1, a);
        step(1'b1, b);
    endtask : cond
    task automatic byte_io(input logic [7:0] d, input logic rd, input logic last, output logic [7:0] q);
        logic k;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(rd ? last : 1'b1, k);
        if (!rd && k !== 1'b0) begin
            missed <= missed + 8'h01;
        end
    endtask : byte_io
    // one word per access; pointer write precedes a repeated start on reads
    task automatic access(input logic rd, input logic [7:0] p, input logic [15:0] w, output logic [15:0] v);
        logic [7:0] q;
        cond(1'b1, 1'b0);
        byte_io({dev_addr, 1'b0}, 1'b0, 1'b0, q);
        byte_io(p, 1'b0, 1'b0, q);
        if (rd) begin
            cond(1'b1, 1'b0);
            byte_io({dev_addr, 1'b1}, 1'b0, 1'b0, q);
        end
        byte_io(rd ? 8'hFF : w[15:8], rd, 1'b0, v[15:8]);
        byte_io(rd ? 8'hFF : w[7:0], rd, 1'b1, v[7:0]);
        cond(1'b0, 1'b1);
    endtask : access
endmodule : serial_host
`default_nettype wire

// >>> test/audio_dsp_control_registers_bench.sv
// bench: register writes and read-back over the two-wire port, audio strobes
// assumes serial_host as the host; clk 20 MHz
`timescale 1ns/100ps
`default_nettype none
module audio_dsp_control_registers_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sample_valid = 1'b0;
    logic sample_sign = 1'b0;
    logic scl, host_sda, sda_o, sda_oe, hi_ok, lo_ok, hmute, pwm, p;
    logic [3:0] a_thr, a_spd, r_thr, r_spd;
    logic signed [5:0] hi_db, lo_db;
    logic [1:0] hi_cf, lo_cf, deemph;
    logic [8:0] coeff;
    logic [7:0] gain, smg, cap, missed;
    logic [15:0] v;
    int fails = 0, n_tests = 0, cycles = 0;
    // pulled-up line, low while either party pulls
    wire logic sda_line = host_sda & ~(sda_oe & ~sda_o);
    wire logic [17:0] shelf = {hi_db, lo_db, hi_ok, lo_ok, hi_cf, lo_cf};
    wire logic [16:0] dsp = {coeff, gain};
    wire logic [10:0] mute = {deemph, hmute, cap};
    localparam logic [15:0] dflt [5] = '{16'h92BA, 16'h12A5, 16'h0004, 16'h10BD, 16'h00BD};
    localparam logic [15:0] wpat [5] = '{16'h5A3C, 16'h2503, 16'h01FF, 16'h0542, 16'h0E7E};
    serial_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(host_sda), .missed(missed));
    audio_dsp_control_registers dut (.clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .sample_valid(sample_valid), .sample_sign(sample_sign), .attack_threshold(a_thr),
        .attack_speed(a_spd), .release_threshold(r_thr), .release_speed(r_spd), .high_shelf_gain_db(hi_db),
        .high_shelf_gain_valid(hi_ok), .high_shelf_corner(hi_cf), .low_shelf_gain_db(lo_db),
        .low_shelf_gain_valid(lo_ok), .low_shelf_corner(lo_cf), .dc_block_coeff(coeff), .gain_code(gain),
        .deemph_select(deemph), .hard_mute_active(hmute), .mute_pwm(pwm), .soft_mute_gain(smg),
        .output_power_cap(cap));
    always #25 clk = ~clk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        host.access(1'b1, a, 16'h0000, v);
        chk("register", 32'(exp), 32'(v));
    endtask : rdchk
    task automatic pulse(input logic s);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample_sign <= s;
        @(posedge clk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : pulse
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("shelf", 32'h0000_0035, 32'(shelf));
        chk("coeff gain", 32'h0000_04BD, 32'(dsp));
        chk("mute ramp", 32'h0000_BDFF, 32'({mute, smg}));
        for (int i = 0; i < 5; i++) begin
            rdchk(dsp_ctrl_pkg::REG_COMP + 8'(i), dflt[i]);
        end
        // each write is read straight back, back to back on the port
        for (int i = 0; i < 5; i++) begin
            host.access(1'b0, dsp_ctrl_pkg::REG_COMP + 8'(i), wpat[i], v);
            rdchk(dsp_ctrl_pkg::REG_COMP + 8'(i), wpat[i]);
        end
        chk("comp", 32'h0000_5A3C, 32'({a_thr, a_spd, r_thr, r_spd}));
        chk("shelf", 32'h0001_2BBB, 32'(shelf));
        chk("coeff gain", 32'h0001_FF42, 32'(dsp));
        chk("mute cap", 32'h0000_077E, 32'(mute));
        @(posedge clk);
        #1 p = pwm;
        @(posedge clk);
        #1 chk("pwm", 32'(!p), 32'(pwm));
        host.access(1'b0, dsp_ctrl_pkg::REG_GAIN, 16'h1033, v);
        pulse(1'b0);
        chk("gain held", 32'h0000_0042, 32'(gain));
        pulse(1'b1);
        chk("gain crossed", 32'h0000_0033, 32'(gain));
        host.access(1'b0, dsp_ctrl_pkg::REG_MUTE, 16'h0100, v);
        repeat (15) pulse(1'b0);
        chk("ramp down", 32'h0000_0000, 32'({hmute, pwm, smg}));
        host.access(1'b0, dsp_ctrl_pkg::REG_MUTE, 16'h0000, v);
        repeat (15) pulse(1'b1);
        chk("ramp up", 32'h0000_00FF, 32'(smg));
        // a reset in mid-run must bring written fields back to their defaults
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk("reset coeff gain", 32'h0000_04BD, 32'(dsp));
        rdchk(dsp_ctrl_pkg::REG_COMP, dflt[0]);
        rdchk(8'h20, 16'h0000);
        chk("acks", 32'h0000_0000, 32'(missed));
        test_done();
    end
    // run is near 35k cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            fails++;
            test_done();
        end
    end
endmodule : audio_dsp_control_registers_bench
`default_nettype wire
